// [dtc_timer.sv]
// Purpose: two 8051-style timer/counters with mode, gate and tick select
// Assumes: pins are asynchronous; register port answers reads one cycle later
// Notes:   overflow flags clear on service acknowledge or software write
//
// Summary of operation
// - Timer B gated by irq pin B high
// - Timer A gated by irq pin A high
// - Timer B counts pin falling edges when selected
// - Timer A counts pin falling edges when selected
// - Mode fields at bits 5:4 and 1:0
// - Mode 0 uses 5-bit low prescaler
// - Mode 1 is full 16-bit count
// - Mode 2 reloads low from high
// - Mode 3 timer A low uses A controls
// - Mode 3 timer A high uses B run bit and B tick only, not B gate or select
// - Mode 3 halts timer B
// - Tick select bit 4 for timer B
// - Tick select bit 3 for timer A
// - Bits 7:6 hold watchdog period select
// - Stretch field bits 2:0, resets to one
// - On-chip data moves always two cycles
// - Overflow flag set by hardware, software clearable
// - Run bits written by software
// - Off-chip data move lasts stretch plus two cycles
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	// Register port
	input  wire dtc_pkg::dtc_bus_type     bus,
	output logic [7:0]                    rdata,
	// Pins
	input  wire logic                     ext_irq_a_pin,
	input  wire logic                     ext_irq_b_pin,
	input  wire logic                     count_input_a_pin,
	input  wire logic                     count_input_b_pin,
	// Interrupt service acknowledges
	input  wire logic                     ack_a,
	input  wire logic                     ack_b,
	// Data move timing
	input  wire dtc_pkg::dtc_external_data_move_req_type external_data_move_req,
	output logic                          external_data_move_busy,
	// Status
	output logic                          timer_a_overflow_flag,
	output logic                          timer_b_overflow_flag,
	output logic [1:0]                    watchdog_period
);
	import dtc_pkg::*;

	// Pin synchronisers: index 0 irq A, 1 irq B, 2 count A, 3 count B
	logic [3:0] s1_reg;
	logic [3:0] s2_reg;
	logic [3:0] s3_reg;
	wire  [3:0] pins = {count_input_b_pin, count_input_a_pin, ext_irq_b_pin, ext_irq_a_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge clk or negedge arst_n)
				if (!arst_n)
				begin
					s1_reg[gi] <= 1'b1;
					s2_reg[gi] <= 1'b1;
					s3_reg[gi] <= 1'b1;
				end
				else
				begin
					s1_reg[gi] <= pins[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
				end
		end
	endgenerate

	wire irq_a  = s2_reg[0];
	wire irq_b  = s2_reg[1];
	wire fall_a = s3_reg[2] & ~s2_reg[2];
	wire fall_b = s3_reg[3] & ~s2_reg[3];

	// Registers
	logic [7:0] mode_reg;
	logic [7:0] tick_reg;
	logic [7:0] a_low_reg, a_high_reg, b_low_reg, b_high_reg;
	logic       a_run_reg, b_run_reg;
	logic       a_flag_reg, b_flag_reg;
	logic [3:0] external_data_move_cnt_reg;
	logic [1:0] mc_cnt_reg;

	wire [1:0] mode_a = mode_reg[MODE_A_M_LO +: 2];
	wire [1:0] mode_b = mode_reg[MODE_B_M_LO +: 2];

	// Internal ticks per timer
	logic tick_a;
	logic tick_b;
	dtc_tick_div u_div_a (
		.clk    (clk),
		.arst_n (arst_n),
		.fast   (tick_reg[TICK_A_SEL]),
		.tick   (tick_a)
	);
	dtc_tick_div u_div_b (
		.clk    (clk),
		.arst_n (arst_n),
		.fast   (tick_reg[TICK_B_SEL]),
		.tick   (tick_b)
	);

	// Enables and count events
	wire en_a   = a_run_reg & (~mode_reg[MODE_A_GATE] | irq_a);
	wire en_b   = b_run_reg & (~mode_reg[MODE_B_GATE] | irq_b);
	wire evt_a  = mode_reg[MODE_A_SEL] ? fall_a : tick_a;
	wire evt_b  = mode_reg[MODE_B_SEL] ? fall_b : tick_b;
	wire inc_a  = en_a & evt_a;
	wire inc_b  = en_b & evt_b & (mode_b != DTC_MSPLIT);
	wire inc_ah = b_run_reg & tick_b;

	// Timer A next state
	logic [7:0] a_low_next, a_high_next;
	logic       a_ovf;
	wire  [8:0] a_low_p1  = {1'b0, a_low_reg} + 9'h001;
	wire  [8:0] a_high_p1 = {1'b0, a_high_reg} + 9'h001;
	wire        a_pre_top = a_low_reg[4:0] == PRESCALE_TOP;

	always_comb
	begin
		a_low_next  = a_low_reg;
		a_high_next = a_high_reg;
		a_ovf       = 1'b0;
		case (mode_a)
			DTC_M13:
				if (inc_a)
				begin
					a_low_next = {3'h0, a_pre_top ? 5'h00 : a_low_reg[4:0] + 5'h01};
					if (a_pre_top)
					begin
						a_high_next = a_high_p1[7:0];
						a_ovf       = a_high_p1[8];
					end
				end
			DTC_M16:
				if (inc_a)
				begin
					a_low_next = a_low_p1[7:0];
					if (a_low_p1[8])
					begin
						a_high_next = a_high_p1[7:0];
						a_ovf       = a_high_p1[8];
					end
				end
			DTC_M8R:
				if (inc_a)
				begin
					a_low_next = a_low_p1[8] ? a_high_reg : a_low_p1[7:0];
					a_ovf      = a_low_p1[8];
				end
			DTC_MSPLIT:
			begin
				if (inc_a)
				begin
					a_low_next = a_low_p1[7:0];
					a_ovf      = a_low_p1[8];
				end
				if (inc_ah)
					a_high_next = a_high_p1[7:0];
			end
			default: ;
		endcase
	end

	// Timer B next state
	logic [7:0] b_low_next, b_high_next;
	logic       b_ovf;
	wire  [8:0] b_low_p1  = {1'b0, b_low_reg} + 9'h001;
	wire  [8:0] b_high_p1 = {1'b0, b_high_reg} + 9'h001;
	wire        b_pre_top = b_low_reg[4:0] == PRESCALE_TOP;

	always_comb
	begin
		b_low_next  = b_low_reg;
		b_high_next = b_high_reg;
		b_ovf       = 1'b0;
		if (inc_b)
			case (mode_b)
				DTC_M13:
				begin
					b_low_next = {3'h0, b_pre_top ? 5'h00 : b_low_reg[4:0] + 5'h01};
					if (b_pre_top)
					begin
						b_high_next = b_high_p1[7:0];
						b_ovf       = b_high_p1[8];
					end
				end
				DTC_M16:
				begin
					b_low_next = b_low_p1[7:0];
					if (b_low_p1[8])
					begin
						b_high_next = b_high_p1[7:0];
						b_ovf       = b_high_p1[8];
					end
				end
				DTC_M8R:
				begin
					b_low_next = b_low_p1[8] ? b_high_reg : b_low_p1[7:0];
					b_ovf      = b_low_p1[8];
				end
				default: ;
			endcase
		// In split mode timer A's high byte borrows timer B's overflow flag
		if (mode_a == DTC_MSPLIT && inc_ah && a_high_p1[8])
			b_ovf = 1'b1;
	end

	// Register decode
	wire wr_mode  = bus.wr && bus.addr == OFS_MODE;
	wire wr_tick  = bus.wr && bus.addr == OFS_TICK;
	wire wr_run   = bus.wr && bus.addr == OFS_RUN;
	wire wr_al    = bus.wr && bus.addr == OFS_A_LOW;
	wire wr_ah    = bus.wr && bus.addr == OFS_A_HIGH;
	wire wr_bl    = bus.wr && bus.addr == OFS_B_LOW;
	wire wr_bh    = bus.wr && bus.addr == OFS_B_HIGH;
	wire wr_external_data_move  = bus.wr && bus.addr == OFS_EXTERNAL_DATA_MOVE;
	wire [7:0] run_view = {b_flag_reg, b_run_reg, a_flag_reg, a_run_reg, 4'h0};

	// Hardware set wins over software or service clear
	wire a_flag_next = a_ovf | (wr_run ? bus.wdata[RUN_A_FLAG] : (a_flag_reg & ~ack_a));
	wire b_flag_next = b_ovf | (wr_run ? bus.wdata[RUN_B_FLAG] : (b_flag_reg & ~ack_b));

	logic [7:0] rd_mux;
	always_comb
		case (bus.addr)
			OFS_MODE:   rd_mux = mode_reg;
			OFS_TICK:   rd_mux = tick_reg;
			OFS_RUN:    rd_mux = run_view;
			OFS_A_LOW:  rd_mux = a_low_reg;
			OFS_A_HIGH: rd_mux = a_high_reg;
			OFS_B_LOW:  rd_mux = b_low_reg;
			OFS_B_HIGH: rd_mux = b_high_reg;
			OFS_EXTERNAL_DATA_MOVE:   rd_mux = {7'h00, external_data_move_busy};
			default:    rd_mux = 8'h00;
		endcase

	// Data move timing: machine cycle is four clocks
	wire       mc_end     = mc_cnt_reg == 2'(CYC_PER_MACHINE - 4'h1);
	wire [3:0] external_data_move_len   = external_data_move_req.on_chip ? EXTERNAL_DATA_MOVE_BASE_CYCLES
	                      : EXTERNAL_DATA_MOVE_BASE_CYCLES + {1'b0, tick_reg[2:0]};
	wire       external_data_move_start = (wr_external_data_move & bus.wdata[0]) | external_data_move_req.start;

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			mode_reg   <= MODE_RESET;
			tick_reg   <= TICK_RESET;
			a_run_reg  <= 1'b0;
			b_run_reg  <= 1'b0;
			a_flag_reg <= 1'b0;
			b_flag_reg <= 1'b0;
			a_low_reg  <= 8'h00;
			a_high_reg <= 8'h00;
			b_low_reg  <= 8'h00;
			b_high_reg <= 8'h00;
			rdata      <= 8'h00;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= bus.wdata;
			if (wr_tick)
				tick_reg <= bus.wdata;
			if (wr_run)
			begin
				a_run_reg <= bus.wdata[RUN_A_RUN];
				b_run_reg <= bus.wdata[RUN_B_RUN];
			end
			a_flag_reg <= a_flag_next;
			b_flag_reg <= b_flag_next;
			a_low_reg  <= wr_al ? bus.wdata : a_low_next;
			a_high_reg <= wr_ah ? bus.wdata : a_high_next;
			b_low_reg  <= wr_bl ? bus.wdata : b_low_next;
			b_high_reg <= wr_bh ? bus.wdata : b_high_next;
			rdata      <= bus.rd ? rd_mux : 8'h00;
		end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			external_data_move_cnt_reg <= 4'h0;
			mc_cnt_reg   <= 2'h0;
			external_data_move_busy    <= 1'b0;
		end
		else if (!external_data_move_busy)
		begin
			if (external_data_move_start)
			begin
				external_data_move_cnt_reg <= external_data_move_len;
				mc_cnt_reg   <= 2'h0;
				external_data_move_busy    <= 1'b1;
			end
		end
		else
		begin
			mc_cnt_reg <= mc_cnt_reg + 2'h1;
			if (mc_end)
			begin
				external_data_move_cnt_reg <= external_data_move_cnt_reg - 4'h1;
				external_data_move_busy    <= external_data_move_cnt_reg != 4'h1;
			end
		end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			timer_a_overflow_flag <= 1'b0;
			timer_b_overflow_flag <= 1'b0;
			watchdog_period       <= 2'h0;
		end
		else
		begin
			timer_a_overflow_flag <= a_flag_next;
			timer_b_overflow_flag <= b_flag_next;
			watchdog_period       <= tick_reg[TICK_WD_LO +: 2];
		end
endmodule : dtc_timer
`default_nettype wire

// [dtc_pkg.sv]
// Purpose: shared constants and types for the dual timer/counter block
// Assumes: byte-wide register port, one 40 MHz clock
// Notes:   offsets are the printed register addresses
package dtc_pkg;
	localparam int          CLK_HZ            = 40000000;
	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  OFS_MODE          = 8'h89;
	localparam logic [7:0]  OFS_A_LOW         = 8'h8A;
	localparam logic [7:0]  OFS_B_LOW         = 8'h8B;
	localparam logic [7:0]  OFS_A_HIGH        = 8'h8C;
	localparam logic [7:0]  OFS_B_HIGH        = 8'h8D;
	localparam logic [7:0]  OFS_TICK          = 8'h8E;
	localparam logic [7:0]  OFS_RUN           = 8'h88;
	localparam logic [7:0]  OFS_EXTERNAL_DATA_MOVE          = 8'hA0;
	localparam int          MODE_B_GATE       = 7;
	localparam int          MODE_B_SEL        = 6;
	localparam int          MODE_B_M_LO       = 4;
	localparam int          MODE_A_GATE       = 3;
	localparam int          MODE_A_SEL        = 2;
	localparam int          MODE_A_M_LO       = 0;
	localparam int          TICK_WD_LO        = 6;
	localparam int          TICK_B_SEL        = 4;
	localparam int          TICK_A_SEL        = 3;
	localparam int          RUN_B_FLAG        = 7;
	localparam int          RUN_B_RUN         = 6;
	localparam int          RUN_A_FLAG        = 5;
	localparam int          RUN_A_RUN         = 4;
	localparam logic [7:0]  MODE_RESET        = 8'h00;
	localparam logic [7:0]  TICK_RESET        = 8'h01;
	localparam logic [3:0]  DIV_FAST          = 4'h4;
	localparam logic [3:0]  DIV_SLOW          = 4'hC;
	localparam logic [3:0]  CYC_PER_MACHINE   = 4'h4;
	localparam logic [3:0]  EXTERNAL_DATA_MOVE_BASE_CYCLES  = 4'h2;
	localparam logic [4:0]  PRESCALE_TOP      = 5'h1F;

	typedef enum logic [1:0] {
		DTC_M13 = 2'h0,
		DTC_M16 = 2'h1,
		DTC_M8R = 2'h2,
		DTC_MSPLIT = 2'h3
	} dtc_mode_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} dtc_bus_type;

	typedef struct packed {
		logic       start;
		logic       on_chip;
	} dtc_external_data_move_req_type;
endpackage : dtc_pkg

// [dtc_tick_div.sv]
// Purpose: one-cycle tick enable at clock/4 or clock/12
// Assumes: clk is the oscillator
// Notes:   counter restarts when the rate changes to avoid a long first period
`timescale 1ns/100ps
`default_nettype none
module dtc_tick_div
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Control
	input  wire logic fast,
	// Tick
	output logic      tick
);
	logic [3:0] cnt_reg;
	logic       fast_reg;
	wire  [3:0] limit   = fast ? DIV_FAST : DIV_SLOW;
	wire        wrap    = (cnt_reg >= limit - 4'h1) || (fast != fast_reg);

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			cnt_reg  <= 4'h0;
			fast_reg <= 1'b0;
			tick     <= 1'b0;
		end
		else
		begin
			cnt_reg  <= wrap ? 4'h0 : cnt_reg + 4'h1;
			fast_reg <= fast;
			tick     <= (fast == fast_reg) && (cnt_reg == limit - 4'h1);
		end
endmodule : dtc_tick_div
`default_nettype wire

// [dtc_timer_sva.sv]
// Purpose: port-level checks for the dual timer/counter
// Assumes: one clock, asynchronous active-low reset
// Notes:   shadows track only what software wrote, not the counts
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_sva
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      arst_n,
	// Watched ports
	input wire dtc_pkg::dtc_bus_type      bus,
	input wire logic [7:0]                rdata,
	input wire logic                      timer_a_overflow_flag,
	input wire dtc_pkg::dtc_external_data_move_req_type external_data_move_req,
	input wire logic                      external_data_move_busy,
	input wire logic [1:0]                watchdog_period
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [5:0] busy_len_reg;
	logic [7:0] mode_sh_reg;
	logic [7:0] tick_sh_reg;
	wire        mode_wr = bus.wr && bus.addr == OFS_MODE;
	wire        tick_wr = bus.wr && bus.addr == OFS_TICK;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			busy_len_reg <= 6'h00;
		else
			busy_len_reg <= external_data_move_busy ? busy_len_reg + 6'h01 : 6'h00;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			mode_sh_reg <= MODE_RESET;
		else if (mode_wr)
			mode_sh_reg <= bus.wdata;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			tick_sh_reg <= TICK_RESET;
		else if (tick_wr)
			tick_sh_reg <= bus.wdata;
	chk_read_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_mode_read: assert property (bus.rd && bus.addr == OFS_MODE |=> rdata == mode_sh_reg)
		else $error("mode register read back wrong");
	chk_tick_read: assert property (bus.rd && bus.addr == OFS_TICK |=> rdata == tick_sh_reg)
		else $error("tick control read back wrong");
	// The period output is registered, so it trails the shadow by one cycle
	chk_wd_follow: assert property (watchdog_period == $past(tick_sh_reg[7:6]))
		else $error("watchdog period does not follow bits 7:6");
	chk_flag_set: assert property (bus.wr && bus.addr == OFS_RUN && bus.wdata[RUN_A_FLAG]
		|=> timer_a_overflow_flag)
		else $error("software set of overflow flag lost");
	chk_busy_start: assert property (external_data_move_req.start && !external_data_move_busy |=> external_data_move_busy)
		else $error("data move did not start");
	chk_onchip_len: assert property (external_data_move_req.start && external_data_move_req.on_chip && !external_data_move_busy
		|=> external_data_move_busy [*8] ##1 !external_data_move_busy)
		else $error("on-chip data move not eight clocks");
	chk_busy_len: assert property ($fell(external_data_move_busy) |-> busy_len_reg[1:0] == 2'h0
		&& busy_len_reg >= 6'h08 && busy_len_reg <= 6'h24)
		else $error("data move length not whole machine cycles in range");
	chk_busy_bound: assert property ($rose(external_data_move_busy) |-> ##[1:36] !external_data_move_busy)
		else $error("data move busy too long");
	cover property ($fell(external_data_move_busy));
	cover property ($rose(timer_a_overflow_flag));
	cover property (bus.rd && bus.addr == OFS_TICK);
endmodule : dtc_timer_sva
`default_nettype wire

// [tb_dual_timer_counter_mode_clock.sv]
// Purpose: self-checking bench for the dual timer/counter
// Assumes: reads answer one cycle later, fast tick for quick overflows
// Notes:   expected values come from the mode rules, not from the design
`timescale 1ns/100ps
`default_nettype none
module tb_dual_timer_counter_mode_clock;
	import dtc_pkg::*;
	logic             clk = 1'b0;
	logic             arst_n = 1'b0;
	dtc_bus_type      bus = '0;
	dtc_external_data_move_req_type mreq = '0;
	logic [7:0]       rdata;
	logic             irq_a = 1'b1;
	logic             cnt_a = 1'b1;
	logic             ack_a = 1'b0;
	logic             irq_b = 1'b1;
	logic             cnt_b = 1'b1;
	logic             ack_b = 1'b0;
	logic             flag_b;
	logic             busy;
	logic             flag_a;
	logic [1:0]       wdp;
	logic [7:0]       lfsr = 8'h4A;
	int               fail_count = 0;
	int               checks_done = 0;
	int               cyc = 0;
	int               n;
	int               exp_q[$];
	dtc_timer u_dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.ext_irq_a_pin(irq_a), .ext_irq_b_pin(irq_b), .count_input_a_pin(cnt_a),
		.count_input_b_pin(cnt_b), .ack_a(ack_a), .ack_b(ack_b), .external_data_move_req(mreq),
		.external_data_move_busy(busy), .timer_a_overflow_flag(flag_a),
		.timer_b_overflow_flag(flag_b), .watchdog_period(wdp));
	always #12.5 clk = ~clk;
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// Hang guard: the whole sequence needs about a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			complete_run();
		end
	end
	function automatic logic [7:0] step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : step
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Each access leaves one idle cycle so no strobe is assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		// Read data stand only until the next edge, so look mid-cycle
		@(negedge clk);
		check("register read", rdata, e);
		@(posedge clk);
	endtask : rc
	task automatic external_data_move(input logic oc, input int exp_len);
		mreq <= '{1'b1, oc};
		@(posedge clk);
		mreq <= '{1'b0, oc};
		n = 0;
		repeat (60)
		begin
			@(negedge clk);
			if (busy === 1'b1)
				n++;
		end
		@(posedge clk);
		check("busy cycles", 8'(n), 8'(exp_len));
	endtask : external_data_move
	task automatic fall_x(input logic on_b, input int k);
		repeat (k)
		begin
			if (on_b)
				cnt_b <= 1'b0;
			else
				cnt_a <= 1'b0;
			repeat (4) @(posedge clk);
			if (on_b)
				cnt_b <= 1'b1;
			else
				cnt_a <= 1'b1;
			repeat (4) @(posedge clk);
		end
	endtask : fall_x
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rc(8'(OFS_MODE + i), (i == 5) ? TICK_RESET : 8'h00);
		external_data_move(1'b0, 12);
		for (int s = 0; s < 8; s++)
		begin
			wr(OFS_TICK, 8'(s));
			external_data_move(1'b0, 4 * (s + 2));
		end
		external_data_move(1'b1, 8);
		wr(OFS_EXTERNAL_DATA_MOVE, 8'h01);
		rc(OFS_EXTERNAL_DATA_MOVE, 8'h01);
		repeat (12) @(posedge clk);
		rc(OFS_EXTERNAL_DATA_MOVE, 8'h00);
		$display("test data move done");
		for (int i = 0; i < 6; i++)
		begin
			lfsr = step(lfsr);
			wr(8'(OFS_MODE + i), lfsr);
			exp_q.push_back(lfsr);
		end
		for (int i = 0; i < 6; i++)
			rc(8'(OFS_MODE + i), 8'(exp_q.pop_front()));
		check("watchdog period", 8'(wdp), 8'(lfsr[7:6]));
		rc(8'h00, 8'h00);
		$display("test registers done");
		for (int m = 0; m < 3; m++)
		begin
			wr(OFS_MODE, 8'(m));
			wr(OFS_TICK, 8'h08);
			wr(OFS_A_LOW, (m == 0) ? 8'h1F : 8'hFF);
			wr(OFS_A_HIGH, (m == 2) ? 8'hA5 : 8'hFF);
			wr(OFS_RUN, 8'h10);
			n = 0;
			while (flag_a !== 1'b1 && n < 100)
			begin
				@(posedge clk);
				n++;
			end
			wr(OFS_RUN, 8'h00);
			rc(OFS_A_LOW, (m == 2) ? 8'hA5 : 8'h00);
			rc(OFS_A_HIGH, (m == 2) ? 8'hA5 : 8'h00);
		end
		wr(OFS_RUN, 8'h20);
		check("overflow flag", 8'(flag_a), 8'h01);
		ack_a <= 1'b1;
		@(posedge clk);
		ack_a <= 1'b0;
		@(posedge clk);
		check("overflow flag", 8'(flag_a), 8'h00);
		$display("test modes done");
		wr(OFS_MODE, 8'h0D);
		wr(OFS_A_LOW, 8'h00);
		irq_a <= 1'b0;
		wr(OFS_RUN, 8'h10);
		fall_x(1'b0, 2);
		rc(OFS_A_LOW, 8'h00);
		irq_a <= 1'b1;
		repeat (4) @(posedge clk);
		fall_x(1'b0, 3);
		rc(OFS_A_LOW, 8'h03);
		wr(OFS_MODE, 8'h30);
		wr(OFS_TICK, 8'h10);
		wr(OFS_B_LOW, 8'h5A);
		wr(OFS_RUN, 8'h40);
		repeat (40) @(posedge clk);
		rc(OFS_B_LOW, 8'h5A);
		$display("test gate and halt done");
		wr(OFS_MODE, 8'hD0);
		wr(OFS_B_LOW, 8'h00);
		irq_b <= 1'b0;
		wr(OFS_RUN, 8'h40);
		fall_x(1'b1, 2);
		rc(OFS_B_LOW, 8'h00);
		irq_b <= 1'b1;
		repeat (4) @(posedge clk);
		fall_x(1'b1, 3);
		rc(OFS_B_LOW, 8'h03);
		wr(OFS_RUN, 8'h00);
		wr(OFS_MODE, 8'h10);
		wr(OFS_B_LOW, 8'hFC);
		wr(OFS_B_HIGH, 8'hFF);
		wr(OFS_RUN, 8'h40);
		n = 0;
		while (flag_b !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		// Four fast ticks: 13 to 16 cycles by phase; the slow rate needs 37 or more
		check("tick rate b", 8'(n >= 13 && n <= 16), 8'h01);
		wr(OFS_RUN, 8'h80);
		check("overflow flag b", 8'(flag_b), 8'h01);
		ack_b <= 1'b1;
		@(posedge clk);
		ack_b <= 1'b0;
		@(posedge clk);
		check("overflow flag b", 8'(flag_b), 8'h00);
		rc(OFS_B_LOW, 8'h00);
		$display("test timer b done");
		wr(OFS_MODE, 8'h33);
		// Flip both tick selects at one edge so both dividers restart in phase
		wr(OFS_TICK, 8'h18);
		wr(OFS_TICK, 8'h00);
		wr(OFS_A_LOW, 8'hFF);
		wr(OFS_A_HIGH, 8'hFF);
		wr(OFS_B_LOW, 8'h5A);
		wr(OFS_RUN, 8'h50);
		n = 0;
		while ((flag_a !== 1'b1 || flag_b !== 1'b1) && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		check("split flags", {6'h00, flag_b, flag_a}, 8'h03);
		wr(OFS_RUN, 8'h00);
		rc(OFS_A_LOW, 8'h00);
		rc(OFS_A_HIGH, 8'h00);
		rc(OFS_B_LOW, 8'h5A);
		$display("test split mode done");
		complete_run();
	end
endmodule : tb_dual_timer_counter_mode_clock
bind dtc_timer dtc_timer_sva u_sva (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
	.timer_a_overflow_flag(timer_a_overflow_flag), .external_data_move_req(external_data_move_req),
	.external_data_move_busy(external_data_move_busy), .watchdog_period(watchdog_period));
`default_nettype wire
